/* File: logic/cma_defs.vh */
// constants, command codes and address map of the core memory addressing block
//
// Summary of operation
// - interrupt entry saves core registers; return restores them
// - return stack: sixteen 15-bit entries, own storage
// - stack overflow/underflow set flags; optional software reset
// - two 16-bit pointers reach data and program
// - pointer read of program memory adds one cycle
// - banked general RAM also reachable linearly
// - program counter is 15 bits, 32K words
// - 8192 words implemented; higher addresses wrap
// - reset starts at 0000h; interrupt vector 0004h
// - pointer high bit 7 selects program memory
// - program word read yields low eight bits
// - pointer writes into program memory do nothing
// - data memory is 32 banks of 128
// - bank: core, SFR, general RAM, common RAM; here 70h-7Fh is per bank, not shared
// - direct accesses use last written bank select
// - unimplemented data memory reads as zero
// - twelve core registers at each bank start
// - flag-updating instruction overrides status flag writes
// - timeout and powerdown flags ignore writes
// - clear of status gives 000u uluu
// - carry flags act as inverted borrows in subtraction (1 = no borrow)
// - nibble carry is carry out of bit 3
// - timeout flag set on power-up/watchdog clear/sleep
`ifndef CMA_DEFS_VH
`define CMA_DEFS_VH

// program space
`define CMA_PC_W          15
`define CMA_PM_AW         13
`define CMA_RESET_VEC     15'h0000
`define CMA_INT_VEC       15'h0004
`define CMA_STK_DEPTH     16
`define CMA_DM_AW         12

// core register indices within every bank
`define CMA_CR_IND0       7'h00
`define CMA_CR_IND1       7'h01
`define CMA_CR_PCL        7'h02
`define CMA_CR_STATUS     7'h03
`define CMA_CR_PTR0L      7'h04
`define CMA_CR_PTR0H      7'h05
`define CMA_CR_PTR1L      7'h06
`define CMA_CR_PTR1H      7'h07
`define CMA_CR_BANK       7'h08
`define CMA_CR_ACC        7'h09
`define CMA_CR_LATH       7'h0a
`define CMA_CR_INTC       7'h0b
`define CMA_CR_COUNT      7'h0c
`define CMA_GPR_BASE      7'h20
`define CMA_GPR_SIZE      7'h50
`define CMA_COMMON_BASE   7'h70

// pointer spaces
`define CMA_LIN_BASE      16'h2000
`define CMA_LIN_LAST      16'h29af
`define CMA_PTR_PM_BIT    15

// status bit positions and interrupt enable bit
`define CMA_ST_C          0
`define CMA_ST_DC         1
`define CMA_ST_Z          2
`define CMA_ST_PD         3
`define CMA_ST_TO         4
`define CMA_INTC_GIE      7

// sequencing commands
`define CMA_OP_NEXT       3'h0
`define CMA_OP_GOTO       3'h1
`define CMA_OP_CALL       3'h2
`define CMA_OP_RETURN     3'h3
`define CMA_OP_RETLIT     3'h4
`define CMA_OP_RETINT     3'h5
`define CMA_OP_RELBR      3'h6
`define CMA_OP_INTENT     3'h7

// wishbone register byte offsets
`define CMA_WB_CTRL       8'h00
`define CMA_WB_PWRCTL     8'h04
`define CMA_WB_PC         8'h08
`define CMA_WB_STATUS     8'h0c
`define CMA_WB_PTR0       8'h10
`define CMA_WB_PTR1       8'h14
`define CMA_WB_BANK       8'h18
`define CMA_WB_ACC        8'h1c
`define CMA_WB_STKCNT     8'h20
`define CMA_PWR_OVF       0
`define CMA_PWR_UNF       1

`endif

/* File: logic/cma_core.v */
// core memory addressing: program counter, return stack, pointers, banking, status
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "cma_defs.vh"

module cma_core #(
	parameter PM_WORDS = 8192,			// implemented program words
	parameter STK_DEPTH = `CMA_STK_DEPTH	// return stack entries
) (
	input  wire        core_clk,
	input  wire        rst_n,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	input  wire [3:0]  wb_sel_i,
	output reg  [31:0] wb_dat_o,
	output wire        wb_ack_o,
	// sequencing command from the decoder
	input  wire        op_valid,
	input  wire [2:0]  op_code,
	input  wire [10:0] op_target,
	input  wire [7:0]  op_literal,
	// file access from the decoder
	input  wire [6:0]  f_addr,
	input  wire        f_rd,
	input  wire        f_wr,
	input  wire [7:0]  f_wdata,
	input  wire [2:0]  f_flag_mask,
	input  wire [2:0]  f_flag_val,
	input  wire        alu_en,
	input  wire        alu_sub,
	output reg  [7:0]  f_rdata,
	output wire        f_busy,
	// reset status events
	input  wire        wdt_clear,
	input  wire        sleep_exec,
	input  wire        wdt_timeout,
	// memory arrays
	output wire [12:0] pm_addr,
	input  wire [13:0] pm_rdata,
	output wire [11:0] dm_addr,
	input  wire [7:0]  dm_rdata,
	output wire [7:0]  dm_wdata,
	output wire        dm_we,
	// state
	output wire [14:0] pc,
	output reg         soft_reset
);

	// =====================================================
	// state machine and storage
	localparam ST_RUN  = 2'b01;			// normal cycles
	localparam ST_PMRD = 2'b10;			// extra cycle for program read

	reg  [1:0]  state_ff;				// one-hot state
	reg  [14:0] pc_ff;				// program counter
	reg  [7:0]  acc_ff;				// accumulator
	reg  [4:0]  bank_ff;				// bank select
	reg  [6:0]  lath_ff;				// program counter latch high
	reg  [7:0]  intc_ff;				// interrupt control
	reg  [15:0] ptr0_ff;				// pointer 0
	reg  [15:0] ptr1_ff;				// pointer 1
	reg         to_ff;				// timeout flag
	reg         pd_ff;				// powerdown flag
	reg  [2:0]  flags_ff;				// z, nibble carry, carry
	reg  [4:0]  stk_cnt_ff;				// entries in use
	reg         ovf_ff;				// stack_overflow_flag
	reg         unf_ff;				// stack_underflow_flag
	reg         stk_rst_en_ff;			// stack fault resets core
	reg  [14:0] pm_ptr_ff;				// latched program read address
	reg         ack_ff;				// wishbone ack
	// shadow copies for interrupt context
	reg  [2:0]  sh_flags_ff;
	reg  [7:0]  sh_acc_ff;
	reg  [4:0]  sh_bank_ff;
	reg  [6:0]  sh_lath_ff;
	reg  [15:0] sh_ptr0_ff;
	reg  [15:0] sh_ptr1_ff;
	wire [14:0] stk_mem [0:STK_DEPTH-1];		// stack entries

	// =====================================================
	// indirect address mapping
	// returns {pm, core, valid, addr[11:0]}
	function [14:0] ind_map;
		input [15:0] p;
		reg   [12:0] lin;				// offset into the linear window
		reg   [12:0] lbank;				// bank that holds the byte
		reg   [12:0] lofs;				// byte within that bank's general ram
		begin
			lin   = p[12:0];			// window base has no bits below 13
			lbank = lin / 13'd80;
			lofs  = lin % 13'd80;
			ind_map = 15'h0000;
			if (p[`CMA_PTR_PM_BIT]) begin
				ind_map[14] = 1'b1;
			end else if (p[15:12] == 4'h0) begin	// traditional banked view
				ind_map = {1'b0, (p[6:0] < `CMA_CR_COUNT), 1'b1, p[11:0]};
			end else if (p >= `CMA_LIN_BASE && p <= `CMA_LIN_LAST) begin
				ind_map = {3'b001, lbank[4:0], `CMA_GPR_BASE + lofs[6:0]};
			end
		end
	endfunction

	// =====================================================
	// access decode
	wire        is_ind    = (f_addr == `CMA_CR_IND0) || (f_addr == `CMA_CR_IND1);
	wire [15:0] sel_ptr   = (f_addr == `CMA_CR_IND1) ? ptr1_ff : ptr0_ff;
	wire [14:0] imap      = ind_map(sel_ptr);
	wire        t_pm      = is_ind & imap[14];
	wire        t_core    = is_ind ? imap[13] : (f_addr < `CMA_CR_COUNT);
	wire        t_valid   = is_ind ? imap[12] : 1'b1;
	wire [11:0] t_addr    = is_ind ? imap[11:0] : {bank_ff, f_addr};
	wire [6:0]  t_idx     = t_addr[6:0];
	wire        run       = state_ff[0];
	wire        pm_req    = run & f_rd & t_pm;

	// alu with borrow semantics on subtract
	wire [7:0]  alu_b     = alu_sub ? ~acc_ff : acc_ff;
	wire [8:0]  alu_sum   = {1'b0, f_wdata} + {1'b0, alu_b} + {8'h00, alu_sub};
	wire [4:0]  alu_nib   = {1'b0, f_wdata[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_sub};
	wire [2:0]  alu_flags = {(alu_sum[7:0] == 8'h00), alu_nib[4], alu_sum[8]};
	wire [2:0]  upd_mask  = alu_en ? 3'b111 : f_flag_mask;
	wire [2:0]  upd_val   = alu_en ? alu_flags : f_flag_val;
	wire [7:0]  wr_val    = alu_en ? alu_sum[7:0] : f_wdata;

	wire        core_wr   = run & f_wr & t_core & t_valid & ~t_pm;
	wire [14:0] pc_inc    = pc_ff + 15'h0001;
	wire        push      = run & op_valid & ((op_code == `CMA_OP_CALL) | (op_code == `CMA_OP_INTENT));
	wire        pop       = run & op_valid & ((op_code == `CMA_OP_RETURN) | (op_code == `CMA_OP_RETLIT) |
				(op_code == `CMA_OP_RETINT));
	wire        stk_full  = (stk_cnt_ff == STK_DEPTH);
	wire        stk_empty = (stk_cnt_ff == 5'h00);
	wire        ovf_evt   = push & stk_full;
	wire        unf_evt   = pop & stk_empty;
	wire [14:0] stk_top   = stk_empty ? `CMA_RESET_VEC : stk_mem[stk_cnt_ff[3:0] - 4'h1];
	wire        wb_req    = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire        wb_wr     = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & wb_sel_i[0];	// lands at the ack edge
	wire [7:0]  status_rd = {3'b000, to_ff, pd_ff, flags_ff};

	assign f_busy   = pm_req;
	assign pc       = pc_ff;
	assign pm_addr  = state_ff[1] ? pm_ptr_ff[12:0] : pc_ff[12:0];
	assign dm_addr  = t_addr;
	assign dm_wdata = wr_val;
	assign dm_we    = run & f_wr & ~t_core & t_valid & ~t_pm;
	assign wb_ack_o = ack_ff;

	// =====================================================
	// return stack entries
	genvar gi;
	generate
		for (gi = 0; gi < STK_DEPTH; gi = gi + 1) begin : g_stk
			reg [14:0] ent_ff;			// one stored return address
			always @(posedge core_clk) begin
				if (!rst_n) begin
					ent_ff <= 15'h0000;
				end else if (push && !stk_full && stk_cnt_ff == gi) begin
					ent_ff <= (op_code == `CMA_OP_INTENT) ? pc_ff : pc_inc;
				end
			end
			assign stk_mem[gi] = ent_ff;
		end
	endgenerate

	// =====================================================
	// sequencing: state, program counter, stack depth
	always @(posedge core_clk) begin
		if (!rst_n || soft_reset) begin
			state_ff   <= ST_RUN;
			pc_ff      <= `CMA_RESET_VEC;
			stk_cnt_ff <= 5'h00;
			pm_ptr_ff  <= 15'h0000;
		end else if (state_ff[1]) begin		// fetch completes
			state_ff <= ST_RUN;
		end else if (pm_req) begin		// stall one cycle
			state_ff  <= ST_PMRD;
			pm_ptr_ff <= sel_ptr[14:0];
		end else begin
			state_ff <= ST_RUN;
			if (push && !stk_full) begin
				stk_cnt_ff <= stk_cnt_ff + 5'h01;
			end
			if (pop && !stk_empty) begin
				stk_cnt_ff <= stk_cnt_ff - 5'h01;
			end
			if (core_wr && t_idx == `CMA_CR_PCL) begin	// computed jump
				pc_ff <= {lath_ff, wr_val};
			end else if (op_valid) begin
				case (op_code)
					`CMA_OP_GOTO, `CMA_OP_CALL: begin
						pc_ff <= {lath_ff[6:3], op_target};
					end
					`CMA_OP_RETURN, `CMA_OP_RETLIT, `CMA_OP_RETINT: begin
						pc_ff <= stk_top;
					end
					`CMA_OP_RELBR: begin
						pc_ff <= pc_inc + {7'h00, acc_ff};
					end
					`CMA_OP_INTENT: begin
						pc_ff <= `CMA_INT_VEC;
					end
					default: begin
						pc_ff <= pc_inc;
					end
				endcase
			end
		end
	end

	// =====================================================
	// core registers, shadows and status
	always @(posedge core_clk) begin
		if (!rst_n || soft_reset) begin
			acc_ff      <= 8'h00;
			bank_ff     <= 5'h00;
			lath_ff     <= 7'h00;
			intc_ff     <= 8'h00;
			ptr0_ff     <= 16'h0000;
			ptr1_ff     <= 16'h0000;
			flags_ff    <= 3'h0;
			sh_flags_ff <= 3'h0;
			sh_acc_ff   <= 8'h00;
			sh_bank_ff  <= 5'h00;
			sh_lath_ff  <= 7'h00;
			sh_ptr0_ff  <= 16'h0000;
			sh_ptr1_ff  <= 16'h0000;
		end else if (run) begin
			// direct writes into core registers
			if (core_wr) begin
				case (t_idx)
					`CMA_CR_STATUS: flags_ff <= wr_val[2:0];
					`CMA_CR_PTR0L:  ptr0_ff[7:0] <= wr_val;
					`CMA_CR_PTR0H:  ptr0_ff[15:8] <= wr_val;
					`CMA_CR_PTR1L:  ptr1_ff[7:0] <= wr_val;
					`CMA_CR_PTR1H:  ptr1_ff[15:8] <= wr_val;
					`CMA_CR_BANK:   bank_ff <= wr_val[4:0];
					`CMA_CR_ACC:    acc_ff <= wr_val;
					`CMA_CR_LATH:   lath_ff <= wr_val[6:0];
					`CMA_CR_INTC:   intc_ff <= wr_val;
					default:        acc_ff <= acc_ff;
				endcase
			end
			// a flag-updating op locks all three flags against a status write
			if (|upd_mask) begin
				flags_ff <= (upd_mask & upd_val) | (~upd_mask & flags_ff);
			end
			if (op_valid && op_code == `CMA_OP_RETLIT) begin
				acc_ff <= op_literal;
			end
			if (op_valid && op_code == `CMA_OP_INTENT) begin
				sh_flags_ff <= flags_ff;
				sh_acc_ff   <= acc_ff;
				sh_bank_ff  <= bank_ff;
				sh_lath_ff  <= lath_ff;
				sh_ptr0_ff  <= ptr0_ff;
				sh_ptr1_ff  <= ptr1_ff;
				intc_ff[`CMA_INTC_GIE] <= 1'b0;
			end
			if (op_valid && op_code == `CMA_OP_RETINT) begin
				flags_ff <= sh_flags_ff;
				acc_ff   <= sh_acc_ff;
				bank_ff  <= sh_bank_ff;
				lath_ff  <= sh_lath_ff;
				ptr0_ff  <= sh_ptr0_ff;
				ptr1_ff  <= sh_ptr1_ff;
				intc_ff[`CMA_INTC_GIE] <= 1'b1;
			end
		end
	end

	// =====================================================
	// timeout and powerdown flags: events only, never written
	always @(posedge core_clk) begin
		if (!rst_n) begin
			to_ff <= 1'b1;
			pd_ff <= 1'b1;
		end else if (wdt_timeout) begin
			to_ff <= 1'b0;
		end else if (sleep_exec) begin
			to_ff <= 1'b1;
			pd_ff <= 1'b0;
		end else if (wdt_clear) begin
			to_ff <= 1'b1;
			pd_ff <= 1'b1;
		end
	end

	// =====================================================
	// file read data
	always @(posedge core_clk) begin
		if (!rst_n) begin
			f_rdata <= 8'h00;
		end else if (state_ff[1]) begin
			f_rdata <= pm_rdata[7:0];
		end else if (run && f_rd && !t_pm) begin
			if (!t_valid) begin
				f_rdata <= 8'h00;
			end else if (t_core) begin
				case (t_idx)
					`CMA_CR_PCL:    f_rdata <= pc_ff[7:0];
					`CMA_CR_STATUS: f_rdata <= status_rd;
					`CMA_CR_PTR0L:  f_rdata <= ptr0_ff[7:0];
					`CMA_CR_PTR0H:  f_rdata <= ptr0_ff[15:8];
					`CMA_CR_PTR1L:  f_rdata <= ptr1_ff[7:0];
					`CMA_CR_PTR1H:  f_rdata <= ptr1_ff[15:8];
					`CMA_CR_BANK:   f_rdata <= {3'b000, bank_ff};
					`CMA_CR_ACC:    f_rdata <= acc_ff;
					`CMA_CR_LATH:   f_rdata <= {1'b0, lath_ff};
					`CMA_CR_INTC:   f_rdata <= intc_ff;
					default:        f_rdata <= 8'h00;	// pointer through pointer
				endcase
			end else begin
				f_rdata <= dm_rdata;
			end
		end
	end

	// =====================================================
	// stack faults, software reset, power control flags
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ovf_ff        <= 1'b0;
			unf_ff        <= 1'b0;
			stk_rst_en_ff <= 1'b0;
			soft_reset    <= 1'b0;
		end else begin
			soft_reset <= stk_rst_en_ff & (ovf_evt | unf_evt);
			if (wb_wr && wb_adr_i == `CMA_WB_CTRL) begin
				stk_rst_en_ff <= wb_dat_i[0];
			end
			// write one clears; a new event in that cycle wins
			ovf_ff <= ovf_evt | (ovf_ff & ~(wb_wr && wb_adr_i == `CMA_WB_PWRCTL && wb_dat_i[`CMA_PWR_OVF]));
			unf_ff <= unf_evt | (unf_ff & ~(wb_wr && wb_adr_i == `CMA_WB_PWRCTL && wb_dat_i[`CMA_PWR_UNF]));
		end
	end

	// =====================================================
	// wishbone slave: one wait state, unmapped reads zero
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ack_ff   <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			ack_ff <= wb_req;
			if (wb_req) begin
				case (wb_adr_i)
					`CMA_WB_CTRL:   wb_dat_o <= {31'h00000000, stk_rst_en_ff};
					`CMA_WB_PWRCTL: wb_dat_o <= {30'h00000000, unf_ff, ovf_ff};
					`CMA_WB_PC:     wb_dat_o <= {17'h00000, pc_ff};
					`CMA_WB_STATUS: wb_dat_o <= {24'h000000, status_rd};
					`CMA_WB_PTR0:   wb_dat_o <= {16'h0000, ptr0_ff};
					`CMA_WB_PTR1:   wb_dat_o <= {16'h0000, ptr1_ff};
					`CMA_WB_BANK:   wb_dat_o <= {27'h0000000, bank_ff};
					`CMA_WB_ACC:    wb_dat_o <= {24'h000000, acc_ff};
					`CMA_WB_STKCNT: wb_dat_o <= {27'h0000000, stk_cnt_ff};
					default:        wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

/* File: verification/cma_core_chk.sv */
// port assertions of the core memory addressing block
`timescale 1ns/1ps
`default_nettype none
`include "cma_defs.vh"
module cma_core_chk (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        op_valid,
	input wire logic [2:0]  op_code,
	input wire logic [6:0]  f_addr,
	input wire logic        f_rd,
	input wire logic        f_wr,
	input wire logic [7:0]  f_wdata,
	input wire logic        alu_en,
	input wire logic [7:0]  f_rdata,
	input wire logic        f_busy,
	input wire logic [13:0] pm_rdata,
	input wire logic [11:0] dm_addr,
	input wire logic [7:0]  dm_rdata,
	input wire logic [7:0]  dm_wdata,
	input wire logic        dm_we,
	input wire logic [14:0] pc,
	input wire logic        soft_reset
);
	// ==========
	// helper state
	logic [7:0] pm_lo_ff; // program byte of the last cycle
	logic       busy_ff;  // last cycle opened a program read
	// capture the previous cycle
	always @(posedge core_clk) begin
		pm_lo_ff <= pm_rdata[7:0];
		busy_ff  <= rst_n & f_busy;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// properties
	AST_WB_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	AST_WB_PULSE: assert property (wb_ack_o |-> $past(wb_stb_i) ##1 !wb_ack_o)
		else $error("ack without request or longer than one cycle");
	AST_RESET_PC: assert property ($rose(rst_n) |-> pc == `CMA_RESET_VEC && !wb_ack_o)
		else $error("pc not at reset vector after reset");
	AST_INT_VEC: assert property (op_valid && op_code == `CMA_OP_INTENT && !f_wr && !busy_ff
		|=> pc == `CMA_INT_VEC || soft_reset) else $error("interrupt entry missed vector");
	AST_PC_STEP: assert property (op_valid && op_code == `CMA_OP_NEXT && !f_wr && !f_busy && !busy_ff
		|=> pc == $past(pc) + 15'h0001) else $error("pc did not advance by one");
	AST_PM_READ: assert property (f_busy && !busy_ff |=> ##1 f_rdata == pm_lo_ff)
		else $error("program read data wrong or not two cycles late");
	AST_DM_MAP: assert property (f_wr && f_addr >= 7'h20 && !busy_ff |-> dm_we && dm_addr[6:0] == f_addr)
		else $error("direct write not mapped to bank offset");
	AST_DM_SRC: assert property (dm_we |-> f_wr && (alu_en || dm_wdata == f_wdata))
		else $error("data memory written without file write");
	AST_DM_READ: assert property (f_rd && f_addr >= 7'h20 && !f_busy && !busy_ff
		|=> f_rdata == $past(dm_rdata)) else $error("direct read data wrong");
	AST_SOFT_RST: assert property (soft_reset |=> pc == `CMA_RESET_VEC && !soft_reset)
		else $error("soft reset not a pulse or pc not cleared");
endmodule
`default_nettype wire

/* File: verification/cma_mem_model.sv */
// program and data memory arrays behind the core
`timescale 1ns/1ps
`default_nettype none
module cma_mem_model (
	input  wire logic        core_clk,
	input  wire logic [12:0] pm_addr,
	output wire logic [13:0] pm_rdata,
	input  wire logic [11:0] dm_addr,
	output wire logic [7:0]  dm_rdata,
	input  wire logic [7:0]  dm_wdata,
	input  wire logic        dm_we
);
	// ==========
	// storage
	logic [7:0] dm [0:4095]; // 32 banks of 128 bytes
	// fixed word pattern over the 8192 implemented words
	assign pm_rdata = {1'b1, pm_addr} ^ 14'h2a55;
	assign dm_rdata = dm[dm_addr];
	// preset contents, not zero
	initial begin
		for (int i = 0; i < 4096; i++) begin
			dm[i] = i[7:0] ^ 8'h96;
		end
	end
	// write port
	always @(posedge core_clk) begin
		if (dm_we) begin
			dm[dm_addr] <= dm_wdata;
		end
	end
endmodule
`default_nettype wire

/* File: verification/cma_core_bench.sv */
// self-checking testbench of the core memory addressing block
`timescale 1ns/1ps
`default_nettype none
`include "cma_defs.vh"
module cma_core_bench;
	// ==========
	// signals
	logic        core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, op_valid, f_rd, f_wr, alu_en, alu_sub;
	logic        wdt_clear, sleep_exec, wdt_timeout, b, s;
	logic [7:0]  wb_adr_i, op_literal, f_wdata, v, x, y;
	logic [31:0] wb_dat_i, d, rnd;
	logic [3:0]  wb_sel_i;
	logic [2:0]  op_code, f_flag_mask, f_flag_val;
	logic [10:0] op_target, e;
	logic [6:0]  f_addr;
	logic [4:0]  bk;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, f_busy, soft_reset, dm_we;
	wire  [7:0]  f_rdata, dm_rdata, dm_wdata;
	wire  [12:0] pm_addr;
	wire  [13:0] pm_rdata;
	wire  [11:0] dm_addr;
	wire  [14:0] pc;
	int          mismatches, compares, scnt, wcnt;
	// ==========
	// design and memories
	cma_core dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .op_valid(op_valid), .op_code(op_code), .op_target(op_target),
		.op_literal(op_literal), .f_addr(f_addr), .f_rd(f_rd), .f_wr(f_wr), .f_wdata(f_wdata),
		.f_flag_mask(f_flag_mask), .f_flag_val(f_flag_val), .alu_en(alu_en), .alu_sub(alu_sub),
		.f_rdata(f_rdata), .f_busy(f_busy), .wdt_clear(wdt_clear), .sleep_exec(sleep_exec),
		.wdt_timeout(wdt_timeout), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
		.dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we), .pc(pc), .soft_reset(soft_reset));
	cma_mem_model mem (.core_clk(core_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
		.dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we));
	// ==========
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] q);
		logic [31:0] t;
		t = q ^ (q << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// result byte and {z,dc,c}
	function automatic logic [10:0] alu_exp(input logic [7:0] a, input logic [7:0] c, input logic sb);
		logic [8:0] r;
		logic       dc;
		r = sb ? {1'b0, a} - {1'b0, c} : {1'b0, a} + {1'b0, c};
		dc = sb ? a[3:0] >= c[3:0] : {1'b0, a[3:0]} + {1'b0, c[3:0]} > 5'h0f;
		return {r[7:0], r[7:0] == 8'h00, dc, sb ? a >= c : r[8]};
	endfunction
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// one classic wishbone cycle, bounded wait for ack
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= wd;
		wb_sel_i <= 4'hf;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 20) begin
			mismatches++;
			results();
		end
	endtask
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0, d);
		chk(n, d, exp);
	endtask
	// one file write from the decoder
	task automatic fw(input logic [6:0] a, input logic [7:0] w, input logic [2:0] m, input logic [2:0] fv,
		input logic al, input logic sb);
		@(posedge core_clk);
		f_wr <= 1'b1;
		f_addr <= a;
		f_wdata <= w;
		f_flag_mask <= m;
		f_flag_val <= fv;
		alu_en <= al;
		alu_sub <= sb;
		@(posedge core_clk);
		f_wr <= 1'b0;
		f_flag_mask <= 3'h0;
		alu_en <= 1'b0;
		#1;
	endtask
	// file read, held one more cycle when it stalls
	task automatic fr(input logic [6:0] a, output logic [7:0] q, output logic bz);
		@(posedge core_clk);
		f_rd <= 1'b1;
		f_addr <= a;
		#1 bz = f_busy;
		@(posedge core_clk);
		if (bz) @(posedge core_clk);
		f_rd <= 1'b0;
		#1 q = f_rdata;
	endtask
	task automatic op(input logic [2:0] c, input logic [10:0] t, input logic [7:0] l);
		@(posedge core_clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_target <= t;
		op_literal <= l;
		@(posedge core_clk);
		op_valid <= 1'b0;
	endtask
	task automatic ev(input logic [2:0] k);
		@(posedge core_clk);
		{wdt_timeout, sleep_exec, wdt_clear} <= k;
		@(posedge core_clk);
		{wdt_timeout, sleep_exec, wdt_clear} <= 3'h0;
	endtask
	// ==========
	// clock, pulse counters, hang guard
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (soft_reset === 1'b1) scnt <= scnt + 1;
		if (dm_we === 1'b1) wcnt <= wcnt + 1;
	end
	initial begin
		#250000;
		mismatches++;
		results();
	end
	// ==========
	// main sequence
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, op_valid, f_rd, f_wr, alu_en, alu_sub, rst_n} = '0;
		{wdt_clear, sleep_exec, wdt_timeout, wb_adr_i, wb_dat_i, wb_sel_i, op_code, op_target} = '0;
		{op_literal, f_addr, f_wdata, f_flag_mask, f_flag_val} = '0;
		rnd = 32'd15609;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rdchk("pc", `CMA_WB_PC, 32'h0);
		rdchk("status", `CMA_WB_STATUS, 32'h18);
		rdchk("depth", `CMA_WB_STKCNT, 32'h0);
		rdchk("unmapped", 8'h40, 32'h0);
		$display("reset test done");
		fw(`CMA_CR_STATUS, 8'hff, 3'h0, 3'h0, 1'b0, 1'b0);
		rdchk("status", `CMA_WB_STATUS, 32'h1f);
		fw(`CMA_CR_STATUS, 8'h07, 3'h7, 3'h0, 1'b0, 1'b0);
		rdchk("status", `CMA_WB_STATUS, 32'h18);
		fw(`CMA_CR_STATUS, 8'h03, 3'h0, 3'h0, 1'b0, 1'b0);
		fw(`CMA_CR_STATUS, 8'h00, 3'h4, 3'h4, 1'b0, 1'b0);
		rdchk("status", `CMA_WB_STATUS, 32'h1f);
		for (int i = 0; i < 3; i++) begin
			ev(3'h4 >> i);
			wb(1'b0, `CMA_WB_STATUS, 32'h0, d);
			chk("status", d & 32'h18, i == 0 ? 32'h08 : i == 1 ? 32'h10 : 32'h18);
		end
		$display("status test done");
		for (int i = 0; i < 10; i++) begin
			rnd = xs(rnd);
			x = i == 0 ? 8'h0f : i == 1 ? 8'h10 : rnd[7:0];
			y = i < 2 ? 8'h01 : rnd[15:8];
			s = i == 1 ? 1'b1 : rnd[16];
			bk = rnd[28:24];
			fw(`CMA_CR_BANK, {3'h0, bk}, 3'h0, 3'h0, 1'b0, 1'b0);
			fw(`CMA_CR_ACC, y, 3'h0, 3'h0, 1'b0, 1'b0);
			fw(7'h20, x, 3'h7, 3'h0, 1'b1, s);
			e = alu_exp(x, y, s);
			chk("gpr", mem.dm[{bk, 7'h20}], e[10:3]);
			wb(1'b0, `CMA_WB_STATUS, 32'h0, d);
			chk("flags", d[2:0], e[2:0]);
			fr(7'h20, v, b);
			chk("gpr_read", v, e[10:3]);
		end
		$display("bank and flag test done");
		fw(`CMA_CR_PTR0L, 8'hbc, 3'h0, 3'h0, 1'b0, 1'b0);
		fw(`CMA_CR_PTR0H, 8'hfa, 3'h0, 3'h0, 1'b0, 1'b0);
		rdchk("ptr0", `CMA_WB_PTR0, 32'hfabc);
		fr(`CMA_CR_IND0, v, b);
		chk("stall", b, 1);
		chk("pm_byte", v, 8'hbc ^ 8'h55);
		d = wcnt;
		fw(`CMA_CR_IND0, 8'h5a, 3'h0, 3'h0, 1'b0, 1'b0);
		chk("pm_write", wcnt, d);
		for (int i = 0; i < 2; i++) begin
			fw(`CMA_CR_PTR1L, i ? 8'haf : 8'h55, 3'h0, 3'h0, 1'b0, 1'b0);
			fw(`CMA_CR_PTR1H, i ? 8'h29 : 8'h20, 3'h0, 3'h0, 1'b0, 1'b0);
			fw(`CMA_CR_IND1, 8'ha7 + i, 3'h0, 3'h0, 1'b0, 1'b0);
			chk("linear", mem.dm[i ? 12'hf6f : 12'h0a5], 8'ha7 + i);
			fr(`CMA_CR_IND1, v, b);
			chk("linear_read", v, 8'ha7 + i);
		end
		$display("pointer test done");
		fw(`CMA_CR_ACC, 8'h5a, 3'h0, 3'h0, 1'b0, 1'b0);
		repeat (3) op(`CMA_OP_NEXT, 11'h0, 8'h0);
		rdchk("pc", `CMA_WB_PC, 32'h3);
		op(`CMA_OP_INTENT, 11'h0, 8'h0);
		rdchk("pc", `CMA_WB_PC, 32'h4);
		fw(`CMA_CR_ACC, 8'h11, 3'h0, 3'h0, 1'b0, 1'b0);
		op(`CMA_OP_RETINT, 11'h0, 8'h0);
		rdchk("pc", `CMA_WB_PC, 32'h3);
		rdchk("acc", `CMA_WB_ACC, 32'h5a);
		$display("interrupt test done");
		op(`CMA_OP_GOTO, 11'h200, 8'h0);
		op(`CMA_OP_RELBR, 11'h0, 8'h0);
		rdchk("pc", `CMA_WB_PC, 32'h25b);
		for (int i = 0; i < 17; i++) op(`CMA_OP_CALL, 11'h100 + i, 8'h0);
		rdchk("depth", `CMA_WB_STKCNT, 32'd16);
		rdchk("overflow", `CMA_WB_PWRCTL, 32'h1);
		wb(1'b1, `CMA_WB_PWRCTL, 32'h1, d);
		op(`CMA_OP_RETLIT, 11'h0, 8'h3c);
		rdchk("acc", `CMA_WB_ACC, 32'h3c);
		rdchk("pc", `CMA_WB_PC, 32'h10f);
		wb(1'b1, `CMA_WB_CTRL, 32'h1, d);
		for (int i = 0; i < 16; i++) op(`CMA_OP_RETURN, 11'h0, 8'h0);
		rdchk("underflow", `CMA_WB_PWRCTL, 32'h2);
		rdchk("pc", `CMA_WB_PC, 32'h0);
		chk("soft_reset", scnt, 1);
		$display("stack test done");
		results();
	end
endmodule
bind cma_core cma_core_chk chk_i (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .op_valid(op_valid), .op_code(op_code), .f_addr(f_addr), .f_rd(f_rd), .f_wr(f_wr),
	.f_wdata(f_wdata), .alu_en(alu_en), .f_rdata(f_rdata), .f_busy(f_busy), .pm_rdata(pm_rdata),
	.dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we), .pc(pc), .soft_reset(soft_reset));
`default_nettype wire
